// File: host_port_host_model.sv
/* host on the multiplexed port; assumes the ready pin is resolved */
`timescale 1ns/1ns
module host_port_host_model (
	input  wire logic clock,
	input  wire logic ready_pin,
	output logic      strobe_a_n = 1'b1,
	output logic      strobe_b_n = 1'b1,
	output logic      dir        = 1'b0
);
	// called at a rising edge; gives up waiting after 40 cycles
	task automatic xfer(input logic d, input logic b, input int hold);
		int n;
		n = 0;
		while (ready_pin !== 1'b1 && n < 40) begin
			@(posedge clock);
			n++;
		end
		strobe_a_n <= b;
		strobe_b_n <= !b;
		dir <= d;
		repeat (hold) @(posedge clock);
		strobe_a_n <= 1'b1;
		strobe_b_n <= 1'b1;
	endtask
endmodule // host_port_host_model

// File: host_port_pin_handshake.sv
/*
 * pin level handshake of the parallel host port: strobes, address strobe,
 * direction, ready and host interrupt outputs.
 * assumes all pins synchronous to clock; the pad ring resolves each
 * tristate pin from its output enable (enable is active low).
 */
`timescale 1ns/1ns
// How it works
// (RULE1) host read/write strobes frame each transfer
// (RULE2) address strobe latches address into address register
// (RULE3) host sets direction for every transfer
// (RULE4) ready low while a transfer is serviced
// (RULE5) ready floats while output disable low
// (RULE6) interrupt output high during reset
// (RULE7) disabled port routes timer one to interrupt
// (RULE8) interrupt floats when output disable low
// (RULE9) enable pin sampled at reset release, sticky
// (RULE10) no interrupts in wide non-multiplexed mode
// (RULE11) host waits for ready before next strobe
module host_port_pin_handshake
	import host_port_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              clock_en,
	input  wire logic              host_strobe_a_n,
	input  wire logic              host_strobe_b_n,
	input  wire logic              host_addr_strobe_n,
	input  wire logic              host_dir,
	input  wire logic [ADDR_W-1:0] host_addr_data_in,
	input  wire logic              output_disable_n,
	input  wire logic              port_enable_pin,
	input  wire logic              wide_nonmux_select,
	input  wire logic              timer_one_out,
	input  wire logic              dsp_irq_request,
	input  wire logic              host_irq_ack,
	output logic                   port_ready_out,
	output logic                   port_ready_oe_n,
	output logic                   host_irq_out,
	output logic                   host_irq_oe_n,
	output logic [ADDR_W-1:0]      host_address_reg,
	output logic                   xfer_write,
	output logic                   xfer_start,
	output logic                   port_enabled
);

	// ----------------------------------------------------------------
	// enable strap
	// ----------------------------------------------------------------
	// the strap is taken on the first enabled clock after reset release,
	// since an async reset may only load a constant
	logic strap_taken_reg;
	logic port_enabled_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			strap_taken_reg  <= 1'b0;
			port_enabled_reg <= 1'b0;
		end else if (clock_en && !strap_taken_reg) begin
			strap_taken_reg  <= 1'b1; // RULE9
			port_enabled_reg <= port_enable_pin; // RULE9
		end
	end

	// ----------------------------------------------------------------
	// strobe decode
	// ----------------------------------------------------------------
	// the two strobes are combined: either one low opens a transfer
	wire strobe_active = !(host_strobe_a_n && host_strobe_b_n); // RULE1
	wire addr_strobe   = !host_addr_strobe_n;
	wire mux_mode      = port_enabled_reg && !wide_nonmux_select;
	wire irq_allowed   = mux_mode; // RULE10

	// ----------------------------------------------------------------
	// transfer state
	// ----------------------------------------------------------------
	port_state_t              state_reg, state_next;
	logic [SERVICE_CNT_W-1:0] count_reg, count_next;
	logic                     strobe_seen_reg;

	wire strobe_rise = strobe_active && !strobe_seen_reg;
	wire count_done  = count_reg == SERVICE_CNT_W'(SERVICE_CYCLES - 1);

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (port_enabled_reg && strobe_rise)
					state_next = ST_ACTIVE; // RULE1
			end
			ST_ACTIVE: begin
				if (!strobe_active) begin
					state_next = ST_SERVICE;
					count_next = '0;
				end
			end
			ST_SERVICE: begin
				count_next = count_reg + SERVICE_CNT_W'(1);
				if (count_done)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg       <= ST_IDLE;
			count_reg       <= '0;
			strobe_seen_reg <= 1'b0;
		end else if (clock_en) begin
			state_reg       <= state_next;
			count_reg       <= count_next;
			strobe_seen_reg <= strobe_active;
		end
	end

	// ----------------------------------------------------------------
	// address latch, direction and start pulse
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			host_address_reg <= ADDR_RESET;
			xfer_write       <= 1'b0;
			xfer_start       <= 1'b0;
		end else if (clock_en) begin
			if (mux_mode && addr_strobe)
				host_address_reg <= host_addr_data_in; // RULE2
			xfer_start <= state_reg == ST_IDLE && port_enabled_reg && strobe_rise;
			if (state_reg == ST_IDLE && strobe_rise)
				xfer_write <= !host_dir; // RULE3
		end
	end

	// ----------------------------------------------------------------
	// ready and interrupt pins
	// ----------------------------------------------------------------
	// irq is active low toward the host; it sets on a dsp request and is
	// released by the host acknowledge, the set winning a same-cycle clear
	logic irq_pend_reg;
	wire  busy_next = state_next != ST_IDLE;
	wire  irq_level = port_enabled_reg ? !(irq_allowed && irq_pend_reg)
		: timer_one_out; // RULE7

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_pend_reg    <= 1'b0;
			port_ready_out  <= READY_RESET;
			port_ready_oe_n <= 1'b1;
			host_irq_out    <= IRQ_RESET_LEVEL; // RULE6
			host_irq_oe_n   <= 1'b0; // RULE6
			port_enabled    <= 1'b0;
		end else if (clock_en) begin
			if (irq_allowed && dsp_irq_request)
				irq_pend_reg <= 1'b1; // RULE10
			else if (host_irq_ack || !irq_allowed)
				irq_pend_reg <= 1'b0;
			port_ready_out  <= port_enabled_reg && !busy_next; // RULE4 RULE11
			port_ready_oe_n <= !output_disable_n; // RULE5
			host_irq_out    <= strap_taken_reg ? irq_level : IRQ_RESET_LEVEL;
			host_irq_oe_n   <= !output_disable_n; // RULE8
			port_enabled    <= port_enabled_reg;
		end
	end

endmodule // host_port_pin_handshake

// File: host_port_pin_handshake_checker.sv
/* output assertions of the host port; assumes clock_en is held high */
`timescale 1ns/1ns
module host_port_pin_handshake_checker
	import host_port_pkg::*;
(
	input wire logic              clock, rst, host_addr_strobe_n, host_dir,
	input wire logic              output_disable_n, wide_nonmux_select, timer_one_out,
	input wire logic              port_ready_out, port_ready_oe_n, host_irq_out,
	input wire logic              host_irq_oe_n, xfer_write, xfer_start, port_enabled,
	input wire logic [ADDR_W-1:0] host_addr_data_in, host_address_reg
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	ready_float_a: assert property (
		!output_disable_n |=> port_ready_oe_n) else $error("ready driven");
	irq_float_a: assert property (
		!output_disable_n |=> host_irq_oe_n) else $error("irq driven");
	irq_reset_a: assert property (
		disable iff (1'b0) rst |-> host_irq_out && !host_irq_oe_n) else $error("irq in reset");
	ready_hold_a: assert property (
		xfer_start |-> !port_ready_out [*6]) else $error("ready early");
	addr_latch_a: assert property (
		!host_addr_strobe_n && port_enabled && !wide_nonmux_select
		|=> host_address_reg == $past(host_addr_data_in)) else $error("address");
	dir_take_a: assert property (
		xfer_start |-> xfer_write == !$past(host_dir)) else $error("direction");
	timer_route_a: assert property (
		!port_enabled && $past(!port_enabled) && $stable(timer_one_out)
		|-> host_irq_out == timer_one_out) else $error("timer route");
	wide_noirq_a: assert property (
		wide_nonmux_select && $past(wide_nonmux_select) && port_enabled
		|-> host_irq_out) else $error("irq in wide mode");
endmodule // host_port_pin_handshake_checker

bind host_port_pin_handshake host_port_pin_handshake_checker i_chk (.*);

// File: host_port_pkg.sv
/*
 * constants for the host port pin handshake: state codes, reset values
 * and the service time of one transfer.
 * assumes a 125 MHz device clock.
 */
package host_port_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS  = 8;
	localparam int SERVICE_TIME_NS  = 48;
	localparam int SERVICE_CYCLES   = (SERVICE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int SERVICE_CNT_W    = 4;

	// ----------------------------------------------------------------
	// widths and reset values
	// ----------------------------------------------------------------
	localparam int         ADDR_W          = 8;
	localparam logic [7:0] ADDR_RESET      = 8'h00;
	localparam logic       IRQ_RESET_LEVEL = 1'b1;
	localparam logic       READY_RESET     = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ACTIVE  = 2'b01,
		ST_SERVICE = 2'b10
	} port_state_t;

endpackage

// File: tb_host_port_pin_handshake.sv
/* bench of the host port handshake; assumes clock_en may stay high */
`timescale 1ns/1ns
module tb_host_port_pin_handshake
	import host_port_pkg::*;
;
	logic clock = 0, rst = 0, clock_en = 1, host_strobe_a_n, host_strobe_b_n, host_dir;
	logic host_addr_strobe_n = 1, output_disable_n = 1, port_enable_pin = 1;
	logic wide_nonmux_select = 0, timer_one_out = 1, dsp_irq_request = 0, host_irq_ack = 0;
	logic [ADDR_W-1:0] host_addr_data_in = 8'h00, host_address_reg;
	logic port_ready_out, port_ready_oe_n, host_irq_out, host_irq_oe_n;
	logic xfer_write, xfer_start, port_enabled, last_write;
	wire  ready_pin = port_ready_oe_n ? 1'bz : port_ready_out;
	int   err_count = 0, samples_checked = 0, starts = 0, n;
	// row: direction, strobe b, address
	logic [9:0] rows [4] = '{10'h0a5, 10'h35a, 10'h1ff, 10'h200};
	always #4 clock = ~clock;
	host_port_pin_handshake i_dut (.*);
	host_port_host_model i_host (.clock(clock), .ready_pin(ready_pin),
		.strobe_a_n(host_strobe_a_n), .strobe_b_n(host_strobe_b_n), .dir(host_dir));
	always @(posedge clock) begin
		if (xfer_start) begin
			starts++;
			last_write = xfer_write;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
	endtask
	task automatic irq(input logic w);
		wide_nonmux_select <= w;
		dsp_irq_request <= 1;
		tick(1);
		dsp_irq_request <= 0;
		tick(3);
		chk(host_irq_out, w);
		host_irq_ack <= 1;
		tick(1);
		host_irq_ack <= 0;
		tick(3);
	endtask
	initial begin
		// a real edge on rst so the async reset loads before the first clock
		rst <= 1;
		tick(5);
		rst <= 0;
		tick(3);
		foreach (rows[i]) begin
			host_addr_strobe_n <= 0;
			host_addr_data_in <= rows[i][7:0];
			tick(1);
			host_addr_strobe_n <= 1;
			n = starts;
			i_host.xfer(rows[i][9], rows[i][8], i + 1);
			tick(2);
			chk(8'(starts - n), 1);
			chk(last_write, !rows[i][9]);
			chk(host_address_reg, rows[i][7:0]);
			chk(port_ready_out, 0);
		end
		irq(0);
		irq(1);
		clock_en <= 0;
		n = starts;
		i_host.xfer(0, 0, 2);
		tick(3);
		chk(8'(starts - n), 0);
		clock_en <= 1;
		tick(3);
		chk(8'(starts - n), 0);
		chk(port_ready_out, 1);
		wide_nonmux_select <= 0;
		output_disable_n <= 0;
		tick(2);
		chk({port_ready_oe_n, host_irq_oe_n}, 8'h03);
		output_disable_n <= 1;
		rst <= 1;
		port_enable_pin <= 0;
		tick(2);
		chk(host_irq_out, 1);
		tick(3);
		rst <= 0;
		tick(3);
		port_enable_pin <= 1;
		timer_one_out <= 0;
		tick(3);
		chk(port_enabled, 0);
		chk(host_irq_out, 0);
		n = starts;
		i_host.xfer(0, 0, 2);
		tick(8);
		chk(8'(starts - n), 0);
		end_of_test();
	end
	initial begin
		tick(3000);
		err_count++;
		end_of_test();
	end
endmodule // tb_host_port_pin_handshake
